// ---- verif/tb_timer_output_irq_unit.sv ----
// Purpose: Self-checking bench for the timer output and interrupt unit.
// Assumes: Registers as laid out in tmrou_pkg.
// Notes:   Changes into modes 1 to 7 pass through mode 7, so no decode glitch can show.
`timescale 1ns/1ps
module tb_timer_output_irq_unit
    import tmrou_pkg::*;
;
    localparam logic [31:0] FI = (32'h1 << CCTL_IE_BIT) | (32'h1 << CCTL_FLAG_BIT);
    logic        clock_i = 1'h0, rstn_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0;
    logic        pwrite_i = 1'h0, counter_tick_i = 1'h0, updown_mode_i = 1'h0, svc = 1'h0;
    logic        global_irq_enable_i = 1'h0, output_hiz_pin_i = 1'h0;
    logic        pready_o, pslverr_o, irq0_ack_i, irq_ch0_o, irq_vec_o, err;
    logic [11:0] paddr_i = 12'h0;
    logic [15:0] counter_value_i = 16'h0;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [6:0]  capture_event_i = 7'h0, channel_output_o, channel_output_oe_o, pins;
    int          mismatches = 0, checked = 0, cyc = 0;
    always #2 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    tmrou_top dut (.clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .counter_value_i, .counter_tick_i, .updown_mode_i,
        .capture_event_i, .global_irq_enable_i, .irq0_ack_i, .output_hiz_pin_i,
        .channel_output_o, .channel_output_oe_o, .irq_ch0_o, .irq_vec_o);
    tmrou_cpu_model #(.LATENCY(4'h3)) u_cpu (.clock_i, .rstn_i, .irq_ch0_i(irq_ch0_o),
        .service_en_i(svc), .out_i(channel_output_o), .oe_i(channel_output_oe_o),
        .irq0_ack_o(irq0_ack_i), .pin_o(pins));
    function automatic logic [11:0] ra(input logic [9:0] b, input int x);
        return {b + IDX_STEP * 10'(x), 2'h0};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_i   <= 1'h1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'h1;
        @(posedge clock_i);
        while (!pready_o) @(posedge clock_i);
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'h0;
        penable_i <= 1'h0;
        @(posedge clock_i);
    endtask
    task automatic tick(input logic [15:0] v);
        counter_value_i <= v;
        counter_tick_i  <= 1'h1;
        @(posedge clock_i);
        counter_tick_i <= 1'h0;
        @(posedge clock_i);
    endtask
    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic t_modes();
        logic [31:0] s;
        apb(1'h1, ra(IDX_CCR0, 0), 32'ha);
        apb(1'h1, ra(IDX_CCR0, 1), 32'h5);
        for (int m = 1; m < 8; m++) begin
            s = 32'(m == 5 || m == 7) << CCTL_OUT_BIT;
            apb(1'h1, ra(IDX_CCTL0, 1), s);
            chk(32'(channel_output_o[1]), s >> CCTL_OUT_BIT);
            apb(1'h1, ra(IDX_CCTL0, 1), s | 32'h7 << CCTL_MODE_LSB);
            apb(1'h1, ra(IDX_CCTL0, 1), s | 32'(m) << CCTL_MODE_LSB);
            tick(16'h4);
            tick(16'h5);
            chk(32'(channel_output_o[1]), 32'(m != 5 && m != 7));
            tick(16'ha);
            tick(16'h0);
            chk(32'(channel_output_o[1]), 32'(8'hd2 >> m) & 32'h1);
        end
        updown_mode_i <= 1'h1;
        apb(1'h1, ra(IDX_CTL, 0), 32'h0);
        apb(1'h1, ra(IDX_CCTL0, 1), 32'h3 << CCTL_MODE_LSB);
        tick(16'ha);
        chk(32'(channel_output_o[1]), 32'h0);
        tick(16'h5);
        chk(32'(channel_output_o[1]), 32'h1);
        tick(16'h1);
        tick(16'h0);
        apb(1'h0, ra(IDX_CTL, 0), 32'h0);
        chk(rd & 32'h1, 32'h1);
        apb(1'h0, ra(IDX_CCTL0, 1), 32'h0);
        chk(rd & 32'h1, 32'h1);
        updown_mode_i <= 1'h0;
        $display("output modes finished");
    endtask
    task automatic t_irq();
        output_hiz_pin_i <= 1'h1;
        apb(1'h1, ra(IDX_HIZ, 0), 32'h1);
        chk(32'(channel_output_oe_o), 32'h0);
        chk(32'(pins), 32'h7f);
        output_hiz_pin_i <= 1'h0;
        global_irq_enable_i <= 1'h1;
        apb(1'h1, ra(IDX_CTL, 0), (32'h1 << CTL_OVF_IE_BIT) | 32'h1);
        for (int x = 1; x < 7; x++) apb(1'h1, ra(IDX_CCTL0, x), FI);
        for (int x = 1; x < 9; x++) begin
            chk(32'(irq_vec_o), 32'(x < 8));
            apb(1'(x == 2), ra(IDX_VEC, 0), 32'h0);
            chk(32'(err), 32'h0);
            if (x != 2) chk(rd, 32'(x == 7 ? VEC_OVF : x == 8 ? VEC_NONE : 4'(2 * x)));
        end
        apb(1'h1, ra(IDX_CCTL0, 5), 32'h1);
        apb(1'h0, ra(IDX_VEC, 0), 32'h0);
        chk(rd, 32'(VEC_NONE));
        apb(1'h1, ra(IDX_CCTL0, 2), (32'h1 << CCTL_CAP_BIT) | FI - 32'h1);
        counter_value_i <= 16'h1234;
        capture_event_i <= 7'h04;
        @(posedge clock_i);
        capture_event_i <= 7'h00;
        apb(1'h0, ra(IDX_CCR0, 2), 32'h0);
        chk(rd, 32'h1234);
        apb(1'h0, ra(IDX_VEC, 0), 32'h0);
        chk(rd, 32'h4);
        apb(1'h1, ra(IDX_CCTL0, 0), FI);
        chk({30'h0, irq_ch0_o, irq_vec_o}, 32'h2);
        global_irq_enable_i <= 1'h0;
        @(posedge clock_i);
        chk(32'(irq_ch0_o), 32'h0);
        global_irq_enable_i <= 1'h1;
        svc <= 1'h1;
        repeat (8) @(posedge clock_i);
        chk(32'(irq_ch0_o), 32'h0);
        $display("interrupts finished");
    endtask
    initial begin
        repeat (6) @(posedge clock_i);
        rstn_i <= 1'h1;
        @(posedge clock_i);
        chk({23'h0, channel_output_o, irq_ch0_o, irq_vec_o}, 32'h0);
        t_modes();
        t_irq();
        complete_run();
    end
endmodule

// ---- verif/tmrou_cpu_model.sv ----
// Purpose: Interrupt-taking processor side and output pins beside the timer.
// Assumes: Pins carry pull-ups, so a released pin reads high.
// Notes:   LATENCY sets how long a channel 0 request waits for service.
`timescale 1ns/1ps
module tmrou_cpu_model
    import tmrou_pkg::*;
#(
    parameter logic [3:0] LATENCY = 4'h2
) (
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    input  wire logic       irq_ch0_i,
    input  wire logic       service_en_i,
    input  wire logic [6:0] out_i,
    input  wire logic [6:0] oe_i,
    output logic            irq0_ack_o,
    output logic [6:0]      pin_o
);
    logic [3:0] wait_reg;
    assign pin_o = (out_i & oe_i) | ~oe_i;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_reg   <= 4'h0;
            irq0_ack_o <= 1'h0;
        end else begin
            wait_reg   <= irq_ch0_i ? wait_reg + 4'h1 : 4'h0;
            irq0_ack_o <= service_en_i && irq_ch0_i && wait_reg == LATENCY;
        end
    end
endmodule

// ---- verif/tmrou_props.sv ----
// Purpose: Port-level properties of the timer output and interrupt unit.
// Assumes: One clock domain; rstn_i is asynchronous and active low.
// Notes:   Write accesses are excluded where they may legally move a flag.
`timescale 1ns/1ps
module tmrou_props
    import tmrou_pkg::*;
(
    input wire logic              clock_i,
    input wire logic              rstn_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [11:0]       paddr_i,
    input wire logic [31:0]       prdata_o,
    input wire logic              counter_tick_i,
    input wire logic              global_irq_enable_i,
    input wire logic              irq0_ack_i,
    input wire logic              output_hiz_pin_i,
    input wire logic [NUM_CH-1:0] channel_output_o,
    input wire logic [NUM_CH-1:0] channel_output_oe_o,
    input wire logic              irq_ch0_o,
    input wire logic              irq_vec_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    wire logic wr_acc = psel_i && penable_i && pwrite_i;
    sequence s_vec_setup;
        psel_i && !penable_i && !pwrite_i && paddr_i == {IDX_VEC, 2'h0};
    endsequence
    property p_vec_idle;
        s_vec_setup ##0 (global_irq_enable_i && !irq_vec_o) |=> prdata_o == 32'h0;
    endproperty
    a_vec_idle: assert property (p_vec_idle) else $error("vector not zero");
    property p_vec_code;
        s_vec_setup |=> prdata_o[31:4] == 28'h0 && !prdata_o[0];
    endproperty
    a_vec_code: assert property (p_vec_code) else $error("vector code malformed");
    property p_still; !$past(counter_tick_i) && !$past(wr_acc) |-> $stable(channel_output_o);
    endproperty
    a_still: assert property (p_still) else $error("output moved without cause");
    property p_oe_pin; !output_hiz_pin_i |-> &channel_output_oe_o; endproperty
    a_oe_pin: assert property (p_oe_pin) else $error("output released, pin low");
    property p_oe_all; channel_output_oe_o == '0 || &channel_output_oe_o; endproperty
    a_oe_all: assert property (p_oe_all) else $error("outputs released apart");
    property p_glob_en; !global_irq_enable_i |-> !irq_ch0_o && !irq_vec_o; endproperty
    a_glob_en: assert property (p_glob_en) else $error("request without global enable");
    property p_ack; irq0_ack_i && !counter_tick_i && !wr_acc |=> !irq_ch0_o; endproperty
    a_ack: assert property (p_ack) else $error("channel 0 request kept");
    property p_rst; $rose(rstn_i) |-> channel_output_o == '0 && !irq_ch0_o; endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear");
endmodule
bind tmrou_top tmrou_props u_props (.clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .prdata_o, .counter_tick_i, .global_irq_enable_i, .irq0_ack_i,
    .output_hiz_pin_i, .channel_output_o, .channel_output_oe_o, .irq_ch0_o, .irq_vec_o);

// ---- verilog/tmrou_irq_vector.sv ----
// Purpose: Interrupt flags, channel 0 request and the prioritised vector word.
// Assumes: Flag index 0..6 are channels, index 7 is the overflow flag.
// Notes:   Hardware set wins over any clear in the same cycle.

`timescale 1ns/1ps

module tmrou_irq_vector
    import tmrou_pkg::*;
(
    input  wire logic                clock_i,
    input  wire logic                rstn_i,
    input  wire logic [NUM_FLAG-1:0] flag_set_i,
    input  wire logic [NUM_FLAG-1:0] sw_we_i,
    input  wire logic [NUM_FLAG-1:0] sw_val_i,
    input  wire logic [NUM_FLAG-1:0] vec_clr_i,
    input  wire logic                irq0_ack_i,
    input  wire logic [NUM_FLAG-1:0] flag_en_i,
    input  wire logic                global_irq_enable_i,
    output logic [NUM_FLAG-1:0]      flags_o,
    output logic [3:0]               vector_code_o,
    output logic [NUM_FLAG-1:0]      vector_top_o,
    output logic                     irq_ch0_o,
    output logic                     irq_vec_o
);

    logic [NUM_FLAG-1:0] flag_reg;
    logic [NUM_FLAG-1:0] flag_next;
    logic [NUM_FLAG-1:0] pend;
    logic [NUM_FLAG-1:0] ack_mask;

    // Lowest channel first, overflow last, channel 0 never.
    function automatic logic [3:0] vec_code(input logic [NUM_FLAG-1:0] p);
        logic [3:0] c;
        c = VEC_NONE;
        if (p[OVF_IDX]) c = VEC_OVF;
        for (int i = NUM_CH - 1; i >= 1; i--) begin
            if (p[i]) c = 4'(2 * i);
        end
        return c;
    endfunction

    assign pend          = flag_reg & flag_en_i;
    assign vector_code_o = vec_code(pend);
    assign ack_mask      = {{(NUM_FLAG-1){1'b0}}, irq0_ack_i};

    always_comb begin
        vector_top_o = '0;
        for (int i = 1; i < NUM_FLAG; i++) begin
            if (vec_code(pend) == ((i == OVF_IDX) ? VEC_OVF : 4'(2 * i))) begin
                vector_top_o[i] = pend[i];
            end
        end
    end

    // Clears first, then software writes, then hardware events.
    assign flag_next = (((flag_reg & ~vec_clr_i & ~ack_mask) & ~sw_we_i)
                       | (sw_val_i & sw_we_i)) | flag_set_i;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flags_o   = flag_reg;
    assign irq_ch0_o = pend[0] & global_irq_enable_i;
    // Stays high while any other enabled flag remains.
    assign irq_vec_o = (|pend[NUM_FLAG-1:1]) & global_irq_enable_i;

endmodule

// ---- verilog/tmrou_output_unit.sv ----
// Purpose: One channel output unit with eight output modes.
// Assumes: Match inputs are one-cycle pulses in the timer clock domain.
// Notes:   Mode 0 passes the software bit straight through.

`timescale 1ns/1ps

module tmrou_output_unit
    import tmrou_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    input  wire logic [2:0] output_mode_sel_i,
    input  wire logic       out_bit_i,
    input  wire logic       channel_match_i,
    input  wire logic       period_match_i,
    output logic            channel_output_o
);

    logic out_reg;
    logic out_next;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // Channel actions win over period actions, so on unit 0 the
    // combined modes collapse to their channel action.
    always_comb begin
        out_next = out_reg;
        unique case (output_mode_sel_i)
            OM_OUTPUT:    out_next = out_bit_i;
            OM_SET:       if (channel_match_i) out_next = 1'b1;
            OM_TOG_RESET: begin
                if (channel_match_i)     out_next = ~out_reg;
                else if (period_match_i) out_next = 1'b0;
            end
            OM_SET_RESET: begin
                if (channel_match_i)     out_next = 1'b1;
                else if (period_match_i) out_next = 1'b0;
            end
            OM_TOGGLE:    if (channel_match_i) out_next = ~out_reg;
            OM_RESET:     if (channel_match_i) out_next = 1'b0;
            OM_TOG_SET:   begin
                if (channel_match_i)     out_next = ~out_reg;
                else if (period_match_i) out_next = 1'b1;
            end
            OM_RESET_SET: begin
                if (channel_match_i)     out_next = 1'b0;
                else if (period_match_i) out_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
        end
    end

    // Mode 0 bypasses the flop; the flop still follows the bit so
    // leaving mode 0 starts from the level already on the pin.
    assign channel_output_o = (output_mode_sel_i == OM_OUTPUT) ? out_bit_i : out_reg;

endmodule

// ---- verilog/tmrou_pkg.sv ----
// Purpose: Shared constants of the timer output and interrupt unit.
// Assumes: APB word index equals the printed register offset; byte address is four times it.
// Notes:   Output modes and vector codes are defined here once.

package tmrou_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_CH   = 7;
    localparam int unsigned NUM_FLAG = 8;
    localparam int unsigned OVF_IDX  = 7;

    // ------------------------------------------------------------
    // Register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_CTL   = 10'h180;
    localparam logic [9:0] IDX_CNT   = 10'h190;
    localparam logic [9:0] IDX_CCTL0 = 10'h182;
    localparam logic [9:0] IDX_CCR0  = 10'h192;
    localparam logic [9:0] IDX_STEP  = 10'h002;
    localparam logic [9:0] IDX_VEC   = 10'h11e;
    localparam logic [9:0] IDX_HIZ   = 10'h1a0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CTL_OVF_FLAG_BIT = 0;
    localparam int unsigned CTL_OVF_IE_BIT   = 1;
    localparam int unsigned CCTL_FLAG_BIT    = 0;
    localparam int unsigned CCTL_OUT_BIT     = 2;
    localparam int unsigned CCTL_IE_BIT      = 4;
    localparam int unsigned CCTL_MODE_LSB    = 5;
    localparam int unsigned CCTL_CAP_BIT     = 8;
    localparam int unsigned HIZ_SEL_BIT      = 0;

    // ------------------------------------------------------------
    // Output modes
    // ------------------------------------------------------------
    localparam logic [2:0] OM_OUTPUT    = 3'h0;
    localparam logic [2:0] OM_SET       = 3'h1;
    localparam logic [2:0] OM_TOG_RESET = 3'h2;
    localparam logic [2:0] OM_SET_RESET = 3'h3;
    localparam logic [2:0] OM_TOGGLE    = 3'h4;
    localparam logic [2:0] OM_RESET     = 3'h5;
    localparam logic [2:0] OM_TOG_SET   = 3'h6;
    localparam logic [2:0] OM_RESET_SET = 3'h7;

    // ------------------------------------------------------------
    // Vector codes and reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  VEC_NONE = 4'h0;
    localparam logic [3:0]  VEC_OVF  = 4'he;
    localparam logic [15:0] CCR_RST  = 16'h0000;
    localparam logic [2:0]  MODE_RST = 3'h0;

endpackage

// ---- verilog/tmrou_top.sv ----
// Purpose: Timer output units and interrupt logic behind an APB slave.
// Assumes: Counter value and direction come from an external counter core.
// Notes:   Reads answer one cycle after setup; pready is high in every access phase.
//
// Chosen here: the APB register port and the register addresses.

`timescale 1ns/1ps

module tmrou_top
    import tmrou_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              rstn_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [11:0]       paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic [15:0]       counter_value_i,
    input  wire logic              counter_tick_i,
    input  wire logic              updown_mode_i,
    input  wire logic [NUM_CH-1:0] capture_event_i,
    input  wire logic              global_irq_enable_i,
    input  wire logic              irq0_ack_i,
    input  wire logic              output_hiz_pin_i,
    output logic [NUM_CH-1:0]      channel_output_o,
    output logic [NUM_CH-1:0]      channel_output_oe_o,
    output logic                   irq_ch0_o,
    output logic                   irq_vec_o
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0]         capcomp_reg [NUM_CH];
    logic [2:0]          mode_reg    [NUM_CH];
    logic [NUM_CH-1:0]   ie_reg;
    logic [NUM_CH-1:0]   outbit_reg;
    logic [NUM_CH-1:0]   cap_reg;
    logic                ovf_ie_reg;
    logic                hiz_sel_reg;
    logic [15:0]         cnt_prev_reg;
    logic [31:0]         prdata_reg;
    logic [NUM_FLAG-1:0] vec_top_reg;

    // ------------------------------------------------------------
    // Event wires
    // ------------------------------------------------------------
    logic [NUM_CH-1:0]   channel_match;
    logic                period_match;
    logic                ovf_event;
    logic [15:0]         period_latch;
    logic [NUM_FLAG-1:0] flag_set;
    logic [NUM_FLAG-1:0] flag_en;
    logic [NUM_FLAG-1:0] flags;
    logic [NUM_FLAG-1:0] vec_top;
    logic [3:0]          vector_word;
    logic [NUM_CH-1:0]   unit_out;

    // ------------------------------------------------------------
    // Bus decode wires
    // ------------------------------------------------------------
    logic                setup_ph;
    logic                access_ph;
    logic                bus_wr;
    logic [NUM_CH-1:0]   cctl_hit;
    logic [NUM_CH-1:0]   ccr_hit;
    logic                ctl_hit;
    logic                cnt_hit;
    logic                vec_hit;
    logic                hiz_hit;
    logic                any_hit;
    logic [NUM_FLAG-1:0] sw_we;
    logic [NUM_FLAG-1:0] sw_val;
    logic [NUM_FLAG-1:0] vec_clr;
    logic [31:0]         read_word;

    assign setup_ph  = psel_i & ~penable_i;
    assign access_ph = psel_i & penable_i;
    assign bus_wr    = access_ph & pwrite_i & any_hit;

    // Word aligned hit for one register index.
    function automatic logic hit(input logic [11:0] a, input logic [9:0] ix);
        return (a[11:2] == ix) && (a[1:0] == 2'b00);
    endfunction

    assign ctl_hit = hit(paddr_i, IDX_CTL);
    assign cnt_hit = hit(paddr_i, IDX_CNT);
    assign vec_hit = hit(paddr_i, IDX_VEC);
    assign hiz_hit = hit(paddr_i, IDX_HIZ);
    assign any_hit = ctl_hit | cnt_hit | vec_hit | hiz_hit | (|cctl_hit) | (|ccr_hit);

    // ------------------------------------------------------------
    // Match and overflow events
    // ------------------------------------------------------------
    assign period_latch = capcomp_reg[0];

    // Up mode acts on the roll from the period value to zero; up/down
    // mode acts when the count equals the period value.
    assign period_match = counter_tick_i & (updown_mode_i
                          ? (counter_value_i == period_latch)
                          : ((counter_value_i == 16'h0000) && (cnt_prev_reg == period_latch)));

    // Overflow in up/down mode only on the 1 to 0 step; otherwise on any
    // wrap back to zero.
    assign ovf_event = counter_tick_i & (counter_value_i == 16'h0000) & (updown_mode_i
                       ? (cnt_prev_reg == 16'h0001)
                       : (cnt_prev_reg != 16'h0000));

    assign channel_match[0] = period_match;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_prev_reg <= 16'h0000;
        end else if (counter_tick_i) begin
            cnt_prev_reg <= counter_value_i;
        end
    end

    // ------------------------------------------------------------
    // Per-channel decode, events and output units
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign cctl_hit[g] = hit(paddr_i, IDX_CCTL0 + 10'(g) * IDX_STEP);
            assign ccr_hit[g]  = hit(paddr_i, IDX_CCR0 + 10'(g) * IDX_STEP);

            if (g > 0) begin : g_match
                // Either count direction counts as a match.
                assign channel_match[g] = counter_tick_i & (counter_value_i == capcomp_reg[g]);
            end

            // Capture mode flags on the capture, compare mode on the match.
            assign flag_set[g] = cap_reg[g] ? capture_event_i[g] : channel_match[g];
            assign flag_en[g]  = ie_reg[g];
            assign sw_we[g]    = bus_wr & cctl_hit[g];
            assign sw_val[g]   = pwdata_i[CCTL_FLAG_BIT];

            tmrou_output_unit u_out (
                .clock_i           (clock_i),
                .rstn_i            (rstn_i),
                .output_mode_sel_i (mode_reg[g]),
                .out_bit_i         (outbit_reg[g]),
                .channel_match_i   (channel_match[g]),
                .period_match_i    (period_match),
                .channel_output_o  (unit_out[g])
            );

            always_ff @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    capcomp_reg[g] <= CCR_RST;
                    mode_reg[g]    <= MODE_RST;
                    ie_reg[g]      <= 1'b0;
                    outbit_reg[g]  <= 1'b0;
                    cap_reg[g]     <= 1'b0;
                end else begin
                    // A capture beats a software write in the same cycle.
                    if (cap_reg[g] && capture_event_i[g]) begin
                        capcomp_reg[g] <= counter_value_i;
                    end else if (bus_wr && ccr_hit[g]) begin
                        capcomp_reg[g] <= pwdata_i[15:0];
                    end
                    if (bus_wr && cctl_hit[g]) begin
                        mode_reg[g]   <= pwdata_i[CCTL_MODE_LSB +: 3];
                        ie_reg[g]     <= pwdata_i[CCTL_IE_BIT];
                        outbit_reg[g] <= pwdata_i[CCTL_OUT_BIT];
                        cap_reg[g]    <= pwdata_i[CCTL_CAP_BIT];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Overflow flag and high-impedance select controls
    // ------------------------------------------------------------
    assign flag_set[OVF_IDX] = ovf_event;
    assign flag_en[OVF_IDX]  = ovf_ie_reg;
    assign sw_we[OVF_IDX]    = bus_wr & ctl_hit;
    assign sw_val[OVF_IDX]   = pwdata_i[CTL_OVF_FLAG_BIT];

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ovf_ie_reg  <= 1'b0;
            hiz_sel_reg <= 1'b0;
        end else begin
            if (bus_wr && ctl_hit) begin
                ovf_ie_reg <= pwdata_i[CTL_OVF_IE_BIT];
            end
            if (bus_wr && hiz_hit) begin
                hiz_sel_reg <= pwdata_i[HIZ_SEL_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags and vector
    // ------------------------------------------------------------
    // The flag cleared by a vector access is the one sampled in the
    // setup cycle, so the cleared flag always matches the code read.
    assign vec_clr = (access_ph && vec_hit) ? vec_top_reg : '0;

    tmrou_irq_vector u_irq (
        .clock_i             (clock_i),
        .rstn_i              (rstn_i),
        .flag_set_i          (flag_set),
        .sw_we_i             (sw_we),
        .sw_val_i            (sw_val),
        .vec_clr_i           (vec_clr),
        .irq0_ack_i          (irq0_ack_i),
        .flag_en_i           (flag_en),
        .global_irq_enable_i (global_irq_enable_i),
        .flags_o             (flags),
        .vector_code_o       (vector_word),
        .vector_top_o        (vec_top),
        .irq_ch0_o           (irq_ch0_o),
        .irq_vec_o           (irq_vec_o)
    );

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        read_word = 32'h0000_0000;
        if (ctl_hit) begin
            read_word[CTL_OVF_FLAG_BIT] = flags[OVF_IDX];
            read_word[CTL_OVF_IE_BIT]   = ovf_ie_reg;
        end
        if (cnt_hit) begin
            read_word[15:0] = counter_value_i;
        end
        if (vec_hit) begin
            read_word[3:0] = vector_word;
        end
        if (hiz_hit) begin
            read_word[HIZ_SEL_BIT] = hiz_sel_reg;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (cctl_hit[i]) begin
                read_word[CCTL_FLAG_BIT]        = flags[i];
                read_word[CCTL_OUT_BIT]         = outbit_reg[i];
                read_word[CCTL_IE_BIT]          = ie_reg[i];
                read_word[CCTL_MODE_LSB +: 3]   = mode_reg[i];
                read_word[CCTL_CAP_BIT]         = cap_reg[i];
            end
            if (ccr_hit[i]) begin
                read_word[15:0] = capcomp_reg[i];
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_reg  <= 32'h0000_0000;
            vec_top_reg <= '0;
        end else if (setup_ph) begin
            prdata_reg  <= read_word;
            vec_top_reg <= vec_hit ? vec_top : '0;
        end
    end

    assign prdata_o  = prdata_reg;
    assign pready_o  = 1'b1;
    assign pslverr_o = access_ph & ~any_hit;

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    assign channel_output_o    = unit_out;
    assign channel_output_oe_o = {NUM_CH{~(hiz_sel_reg & output_hiz_pin_i)}};

endmodule
